// >>> inc/radio_link_map.vh
// Constants and register map for the radio link performance monitor
`ifndef RADIO_LINK_MAP_VH
`define RADIO_LINK_MAP_VH

// Timebase: one measurement period in ms, clock rate in kHz
`define PERIOD_MS       250
`define CLK_KHZ         20000
`define LAST_PHASE      2'h3
// Weighted filter: 0.7 of the new rate in 0.16 fixed point
`define GH_WEIGHT       17'h0B333
`define GH_ONE          17'h10000
// Severe second: error share of 3/10 or more
`define SES_NUM         4'h3
`define SES_DEN         4'hA
// Availability: run of ten seconds, nine already booked
`define RUN_LAST        4'h9
`define RUN_BOOK        32'h0000000A
`define RUN_UNBOOK      32'h00000009
// Register word addresses (byte offsets)
`define ADDR_CTRL       8'h00
`define ADDR_IRQ_STAT   8'h04
`define ADDR_IRQ_MASK   8'h08
`define ADDR_THR_MINOR  8'h0C
`define ADDR_THR_MAJOR  8'h10
`define ADDR_THR_CRIT   8'h14
`define ADDR_THR_ESR    8'h18
`define ADDR_THR_SEVERE_SECOND_RATIO   8'h1C
`define ADDR_THR_BACKGROUND_BLOCK_RATIO   8'h20
`define ADDR_RATE       8'h24
`define ADDR_FILT       8'h28
`define ADDR_ESR        8'h2C
`define ADDR_SEVERE_SECOND_RATIO       8'h30
`define ADDR_BACKGROUND_BLOCK_RATIO       8'h34
`define ADDR_TOT_SECS   8'h38
`define ADDR_UNAV_SECS  8'h3C
`define ADDR_ES_CNT     8'h40
`define ADDR_SES_CNT    8'h44
`define ADDR_FLAGS      8'h48
`define ADDR_LEVEL      8'h4C
// Control bits
`define CTRL_EN         0
`define CTRL_CLR        1
// Interrupt status and mask bits
`define IRQ_MINOR       0
`define IRQ_MAJOR       1
`define IRQ_CRIT        2
`define IRQ_OUTAGE      3
`define IRQ_LOCAL       4
`define IRQ_FAR         5
`define IRQ_ROLLBACK    6
`define IRQ_RATIO       7
`define IRQ_W           8

`endif

// >>> rtl/ratio_divider.v
// Serial divider giving num/den as a 0.16 fraction, saturating at one
module ratio_divider
#(
	parameter NUM_W  = 32,
	parameter FRAC_W = 16
)
(
	input  wire              core_clk_i,
	input  wire              resetn_i,
	input  wire              start_i,
	input  wire [NUM_W-1:0]  num_i,
	input  wire [NUM_W-1:0]  den_i,
	output wire [FRAC_W-1:0] quo_o,
	output wire              done_o
);
	localparam [5:0] STEPS = FRAC_W;

	reg [NUM_W-1:0]  den_q;
	reg [NUM_W:0]    rem_q;
	reg [FRAC_W-1:0] acc_q;
	reg [FRAC_W-1:0] quo_q;
	reg [5:0]        cnt_q;
	reg              busy_q;
	reg              done_q;

	wire [NUM_W:0]    shifted = {rem_q[NUM_W-1:0], 1'b0};
	wire              fits    = shifted >= {1'b0, den_q};
	wire [FRAC_W-1:0] acc_nx  = {acc_q[FRAC_W-2:0], fits};

	// One quotient bit per cycle; a new start restarts the division
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			den_q  <= {NUM_W{1'b0}};
			rem_q  <= {(NUM_W+1){1'b0}};
			acc_q  <= {FRAC_W{1'b0}};
			quo_q  <= {FRAC_W{1'b0}};
			cnt_q  <= 6'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (start_i)
			begin
				den_q <= den_i;
				rem_q <= {1'b0, num_i};
				acc_q <= {FRAC_W{1'b0}};
				cnt_q <= STEPS;
				// Empty interval reads zero, full error reads all ones
				busy_q <= (den_i != {NUM_W{1'b0}}) && (num_i < den_i);
				if (den_i == {NUM_W{1'b0}})
				begin
					quo_q  <= {FRAC_W{1'b0}};
					done_q <= 1'b1;
				end
				else if (num_i >= den_i)
				begin
					quo_q  <= {FRAC_W{1'b1}};
					done_q <= 1'b1;
				end
			end
			else if (busy_q)
			begin
				rem_q <= fits ? (shifted - {1'b0, den_q}) : shifted;
				acc_q <= acc_nx;
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01)
				begin
					busy_q <= 1'b0;
					quo_q  <= acc_nx;
					done_q <= 1'b1;
				end
			end
		end
	end

	assign quo_o  = quo_q;
	assign done_o = done_q;
endmodule // ratio_divider

// >>> rtl/limit_compare.v
// Registered over-threshold flag; a zero limit disables the flag
module limit_compare
#(
	parameter W = 16
)
(
	input  wire         core_clk_i,
	input  wire         resetn_i,
	input  wire [W-1:0] value_i,
	input  wire [W-1:0] limit_i,
	output wire         over_o
);
	reg over_q;

	// Set above the limit, drops again once back at or below it
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			over_q <= 1'b0;
		else
			over_q <= (limit_i != {W{1'b0}}) && (value_i > limit_i);
	end

	assign over_o = over_q;
endmodule // limit_compare

// >>> rtl/radio_link_performance_monitor.v
// Link quality monitor: error rates, filtered rate, seconds, availability, flags
`include "radio_link_map.vh"

module radio_link_performance_monitor
#(
	parameter PERIOD_CYCLES = `PERIOD_MS * `CLK_KHZ,
	parameter TB_W          = 23,
	parameter CNT_W         = 24,
	parameter RATE_W        = 16
)
(
	input  wire              core_clk_i,
	input  wire              resetn_i,
	input  wire              pkt_valid_i,
	input  wire              pkt_uncorr_i,
	input  wire              frame_lock_i,
	input  wire              far_end_lock_i,
	input  wire [7:0]        rssi_dbm_i,
	input  wire              rollback_evt_i,
	input  wire [7:0]        addr_i,
	input  wire [31:0]       wr_data_i,
	input  wire              wr_en_i,
	input  wire              rd_en_i,
	output wire [31:0]       rd_data_o,
	output wire              irq_o,
	output wire              tx_lock_status_o,
	output wire              local_frame_loss_o,
	output wire              far_end_frame_loss_o,
	output wire              link_outage_flag_o,
	output wire              minor_rate_over_o,
	output wire              major_rate_over_o,
	output wire              critical_rate_over_o,
	output wire              errored_second_ratio_over_o,
	output wire              severe_second_ratio_over_o,
	output wire              background_block_ratio_over_o,
	output wire              settings_rolled_back_o,
	output wire [7:0]        received_level_gauge_o,
	output wire [RATE_W-1:0] current_error_rate_o,
	output wire [RATE_W-1:0] peak_error_rate_o
);
	localparam [TB_W-1:0] TB_LAST   = PERIOD_CYCLES - 1;
	localparam            SW        = CNT_W + 2;
	localparam [1:0]      ST_AVAIL  = 2'b01;
	localparam [1:0]      ST_OUTAGE = 2'b10;

	reg  [TB_W-1:0]    tb_q;
	reg  [1:0]         phase_q;
	reg  [1:0]         per_phase_q;
	reg  [CNT_W-1:0]   per_tot_q;
	reg  [CNT_W-1:0]   per_err_q;
	reg  [SW-1:0]      sec_tot_q;
	reg  [SW-1:0]      sec_err_q;
	reg  [31:0]        blk_tot_q;
	reg  [31:0]        blk_err_q;
	reg  [31:0]        tot_secs_q;
	reg  [31:0]        unav_secs_q;
	reg  [31:0]        es_cnt_q;
	reg  [31:0]        ses_cnt_q;
	reg  [1:0]         state_q;
	reg  [3:0]         run_q;
	reg                sec_tick_q;
	reg  [RATE_W-1:0]  cur_rate_q;
	reg  [RATE_W-1:0]  peak_q;
	reg  [RATE_W-1:0]  peak_run_q;
	reg  [RATE_W-1:0]  filt_q;
	reg                en_q;
	reg                clr_q;
	reg  [`IRQ_W-1:0]  stat_q;
	reg  [`IRQ_W-1:0]  mask_q;
	reg  [RATE_W-1:0]  thr_minor_q;
	reg  [RATE_W-1:0]  thr_major_q;
	reg  [RATE_W-1:0]  thr_crit_q;
	reg  [RATE_W-1:0]  thr_esr_q;
	reg  [RATE_W-1:0]  thr_severe_second_ratio_q;
	reg  [RATE_W-1:0]  thr_background_block_ratio_q;
	reg  [7:0]         level_q;
	reg  [`IRQ_W-1:0]  lvl_prev_q;
	reg  [31:0]        rd_q;
	reg  [31:0]        rd_d;

	wire [RATE_W-1:0]  per_quo;
	wire               per_done;
	wire [RATE_W-1:0]  esr_quo;
	wire [RATE_W-1:0]  severe_second_ratio_quo;
	wire [RATE_W-1:0]  background_block_ratio_quo;
	wire               minor_over;
	wire               major_over;
	wire               crit_over;
	wire               esr_over;
	wire               severe_second_ratio_over;
	wire               background_block_ratio_over;

	// Timebase only advances while monitoring is enabled
	wire period_tick = en_q && (tb_q == TB_LAST);
	wire sec_tick    = period_tick && (phase_q == `LAST_PHASE);
	wire pkt         = en_q && pkt_valid_i;
	wire bad         = pkt && pkt_uncorr_i;

	// Severe second test: err * 10 >= tot * 3, needs at least one error
	wire [SW+3:0] ses_lhs = sec_err_q * `SES_DEN;
	wire [SW+3:0] ses_rhs = sec_tot_q * `SES_NUM;
	wire          es_now  = sec_err_q != {SW{1'b0}};
	wire          ses_now = es_now && (ses_lhs >= ses_rhs);

	// Weighted filter in 0.16 fixed point
	wire [33:0] gh_sum = per_quo * `GH_WEIGHT + filt_q * (`GH_ONE - `GH_WEIGHT);
	wire [RATE_W-1:0] peak_nx = (per_quo > peak_run_q) ? per_quo : peak_run_q;

	// Timebase and per-period packet counts
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tb_q      <= {TB_W{1'b0}};
			phase_q   <= 2'h0;
			per_tot_q <= {CNT_W{1'b0}};
			per_err_q <= {CNT_W{1'b0}};
			sec_tot_q <= {SW{1'b0}};
			sec_err_q <= {SW{1'b0}};
			blk_tot_q <= 32'h00000000;
			blk_err_q <= 32'h00000000;
		end
		else if (clr_q)
		begin
			tb_q      <= {TB_W{1'b0}};
			phase_q   <= 2'h0;
			per_tot_q <= {CNT_W{1'b0}};
			per_err_q <= {CNT_W{1'b0}};
			sec_tot_q <= {SW{1'b0}};
			sec_err_q <= {SW{1'b0}};
			blk_tot_q <= 32'h00000000;
			blk_err_q <= 32'h00000000;
		end
		else
		begin
			if (en_q)
				tb_q <= period_tick ? {TB_W{1'b0}} : tb_q + {{(TB_W-1){1'b0}}, 1'b1};
			if (period_tick)
				phase_q <= phase_q + 2'h1;
			// Boundary packet opens the next interval
			per_tot_q <= (period_tick ? {CNT_W{1'b0}} : per_tot_q) + {{(CNT_W-1){1'b0}}, pkt};
			per_err_q <= (period_tick ? {CNT_W{1'b0}} : per_err_q) + {{(CNT_W-1){1'b0}}, bad};
			sec_tot_q <= (sec_tick ? {SW{1'b0}} : sec_tot_q) + {{(SW-1){1'b0}}, pkt};
			sec_err_q <= (sec_tick ? {SW{1'b0}} : sec_err_q) + {{(SW-1){1'b0}}, bad};
			blk_tot_q <= blk_tot_q + {31'h00000000, pkt};
			blk_err_q <= blk_err_q + {31'h00000000, bad};
		end
	end

	// Per-period error rate
	ratio_divider #(.NUM_W(CNT_W), .FRAC_W(RATE_W)) u_per_div
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.start_i    (period_tick),
		.num_i      (per_err_q),
		.den_i      (per_tot_q),
		.quo_o      (per_quo),
		.done_o     (per_done)
	);

	// Current, peak and filtered rates, updated when a division lands
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cur_rate_q  <= {RATE_W{1'b0}};
			peak_q      <= {RATE_W{1'b0}};
			peak_run_q  <= {RATE_W{1'b0}};
			filt_q      <= {RATE_W{1'b0}};
			per_phase_q <= 2'h0;
		end
		else if (clr_q)
		begin
			cur_rate_q  <= {RATE_W{1'b0}};
			peak_q      <= {RATE_W{1'b0}};
			peak_run_q  <= {RATE_W{1'b0}};
			filt_q      <= {RATE_W{1'b0}};
			per_phase_q <= 2'h0;
		end
		else if (per_done)
		begin
			cur_rate_q  <= per_quo;
			filt_q      <= gh_sum[31:16];
			per_phase_q <= per_phase_q + 2'h1;
			// Peak covers the four periods of the last complete second
			if (per_phase_q == `LAST_PHASE)
			begin
				peak_q     <= peak_nx;
				peak_run_q <= {RATE_W{1'b0}};
			end
			else
				peak_run_q <= peak_nx;
		end
	end

	// Seconds counters and availability state
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tot_secs_q  <= 32'h00000000;
			unav_secs_q <= 32'h00000000;
			es_cnt_q    <= 32'h00000000;
			ses_cnt_q   <= 32'h00000000;
			state_q     <= ST_AVAIL;
			run_q       <= 4'h0;
			sec_tick_q  <= 1'b0;
		end
		else if (clr_q)
		begin
			tot_secs_q  <= 32'h00000000;
			unav_secs_q <= 32'h00000000;
			es_cnt_q    <= 32'h00000000;
			ses_cnt_q   <= 32'h00000000;
			state_q     <= ST_AVAIL;
			run_q       <= 4'h0;
			sec_tick_q  <= 1'b0;
		end
		else
		begin
			sec_tick_q <= sec_tick;
			if (sec_tick)
			begin
				tot_secs_q <= tot_secs_q + 32'h00000001;
				es_cnt_q   <= es_cnt_q + {31'h00000000, es_now};
				ses_cnt_q  <= ses_cnt_q + {31'h00000000, ses_now};
				case (state_q)
					ST_AVAIL:
					begin
						run_q <= ses_now ? run_q + 4'h1 : 4'h0;
						// Tenth severe second: book all ten as outage
						if (ses_now && run_q == `RUN_LAST)
						begin
							state_q     <= ST_OUTAGE;
							run_q       <= 4'h0;
							unav_secs_q <= unav_secs_q + `RUN_BOOK;
						end
					end
					ST_OUTAGE:
					begin
						run_q <= ses_now ? 4'h0 : run_q + 4'h1;
						// Tenth clean second: hand the nine before it back
						if (!ses_now && run_q == `RUN_LAST)
						begin
							state_q     <= ST_AVAIL;
							run_q       <= 4'h0;
							unav_secs_q <= unav_secs_q - `RUN_UNBOOK;
						end
						else
							unav_secs_q <= unav_secs_q + 32'h00000001;
					end
					default:
					begin
						state_q <= ST_AVAIL;
						run_q   <= 4'h0;
					end
				endcase
			end
		end
	end

	// Ratios start one cycle after the second closes, on settled counts
	ratio_divider #(.NUM_W(32), .FRAC_W(RATE_W)) u_esr_div
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.start_i    (sec_tick_q),
		.num_i      (es_cnt_q),
		.den_i      (tot_secs_q),
		.quo_o      (esr_quo),
		.done_o     ()
	);

	ratio_divider #(.NUM_W(32), .FRAC_W(RATE_W)) u_severe_second_ratio_div
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.start_i    (sec_tick_q),
		.num_i      (ses_cnt_q),
		.den_i      (tot_secs_q),
		.quo_o      (severe_second_ratio_quo),
		.done_o     ()
	);

	ratio_divider #(.NUM_W(32), .FRAC_W(RATE_W)) u_background_block_ratio_div
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.start_i    (sec_tick_q),
		.num_i      (blk_err_q),
		.den_i      (blk_tot_q),
		.quo_o      (background_block_ratio_quo),
		.done_o     ()
	);

	// Filtered rate thresholds
	limit_compare #(.W(RATE_W)) u_minor
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.value_i    (filt_q),
		.limit_i    (thr_minor_q),
		.over_o     (minor_over)
	);

	limit_compare #(.W(RATE_W)) u_major
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.value_i    (filt_q),
		.limit_i    (thr_major_q),
		.over_o     (major_over)
	);

	limit_compare #(.W(RATE_W)) u_crit
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.value_i    (filt_q),
		.limit_i    (thr_crit_q),
		.over_o     (crit_over)
	);

	// Ratio thresholds
	limit_compare #(.W(RATE_W)) u_esr
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.value_i    (esr_quo),
		.limit_i    (thr_esr_q),
		.over_o     (esr_over)
	);

	limit_compare #(.W(RATE_W)) u_severe_second_ratio
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.value_i    (severe_second_ratio_quo),
		.limit_i    (thr_severe_second_ratio_q),
		.over_o     (severe_second_ratio_over)
	);

	limit_compare #(.W(RATE_W)) u_background_block_ratio
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.value_i    (background_block_ratio_quo),
		.limit_i    (thr_background_block_ratio_q),
		.over_o     (background_block_ratio_over)
	);

	// Levels watched for rising edges; rollback is already a pulse
	wire [`IRQ_W-1:0] lvl = {esr_over | severe_second_ratio_over | background_block_ratio_over, 1'b0, !far_end_lock_i,
	                         !frame_lock_i, state_q == ST_OUTAGE, crit_over, major_over,
	                         minor_over};
	wire [`IRQ_W-1:0] evt = (lvl & ~lvl_prev_q) | {1'b0, rollback_evt_i, 6'h00};
	wire [`IRQ_W-1:0] w1c = (wr_en_i && addr_i == `ADDR_IRQ_STAT) ? wr_data_i[`IRQ_W-1:0]
	                                                               : {`IRQ_W{1'b0}};

	// Register writes; a set in the clearing cycle wins over the clear
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			en_q        <= 1'b0;
			clr_q       <= 1'b0;
			stat_q      <= {`IRQ_W{1'b0}};
			mask_q      <= {`IRQ_W{1'b0}};
			lvl_prev_q  <= {`IRQ_W{1'b0}};
			thr_minor_q <= {RATE_W{1'b0}};
			thr_major_q <= {RATE_W{1'b0}};
			thr_crit_q  <= {RATE_W{1'b0}};
			thr_esr_q   <= {RATE_W{1'b0}};
			thr_severe_second_ratio_q  <= {RATE_W{1'b0}};
			thr_background_block_ratio_q  <= {RATE_W{1'b0}};
			level_q     <= 8'h00;
		end
		else
		begin
			clr_q      <= wr_en_i && addr_i == `ADDR_CTRL && wr_data_i[`CTRL_CLR];
			lvl_prev_q <= lvl;
			level_q    <= rssi_dbm_i;
			stat_q     <= (stat_q & ~w1c) | evt;
			if (wr_en_i)
			begin
				case (addr_i)
					`ADDR_CTRL:      en_q        <= wr_data_i[`CTRL_EN];
					`ADDR_IRQ_MASK:  mask_q      <= wr_data_i[`IRQ_W-1:0];
					`ADDR_THR_MINOR: thr_minor_q <= wr_data_i[RATE_W-1:0];
					`ADDR_THR_MAJOR: thr_major_q <= wr_data_i[RATE_W-1:0];
					`ADDR_THR_CRIT:  thr_crit_q  <= wr_data_i[RATE_W-1:0];
					`ADDR_THR_ESR:   thr_esr_q   <= wr_data_i[RATE_W-1:0];
					`ADDR_THR_SEVERE_SECOND_RATIO:  thr_severe_second_ratio_q  <= wr_data_i[RATE_W-1:0];
					`ADDR_THR_BACKGROUND_BLOCK_RATIO:  thr_background_block_ratio_q  <= wr_data_i[RATE_W-1:0];
					default:         en_q        <= en_q;
				endcase
			end
		end
	end

	// Read decode; unmapped addresses read zero
	always @*
	begin
		rd_d = 32'h00000000;
		case (addr_i)
			`ADDR_CTRL:      rd_d = {31'h00000000, en_q};
			`ADDR_IRQ_STAT:  rd_d = {24'h000000, stat_q};
			`ADDR_IRQ_MASK:  rd_d = {24'h000000, mask_q};
			`ADDR_THR_MINOR: rd_d = {16'h0000, thr_minor_q};
			`ADDR_THR_MAJOR: rd_d = {16'h0000, thr_major_q};
			`ADDR_THR_CRIT:  rd_d = {16'h0000, thr_crit_q};
			`ADDR_THR_ESR:   rd_d = {16'h0000, thr_esr_q};
			`ADDR_THR_SEVERE_SECOND_RATIO:  rd_d = {16'h0000, thr_severe_second_ratio_q};
			`ADDR_THR_BACKGROUND_BLOCK_RATIO:  rd_d = {16'h0000, thr_background_block_ratio_q};
			`ADDR_RATE:      rd_d = {peak_q, cur_rate_q};
			`ADDR_FILT:      rd_d = {16'h0000, filt_q};
			`ADDR_ESR:       rd_d = {16'h0000, esr_quo};
			`ADDR_SEVERE_SECOND_RATIO:      rd_d = {16'h0000, severe_second_ratio_quo};
			`ADDR_BACKGROUND_BLOCK_RATIO:      rd_d = {16'h0000, background_block_ratio_quo};
			`ADDR_TOT_SECS:  rd_d = tot_secs_q;
			`ADDR_UNAV_SECS: rd_d = unav_secs_q;
			`ADDR_ES_CNT:    rd_d = es_cnt_q;
			`ADDR_SES_CNT:   rd_d = ses_cnt_q;
			`ADDR_FLAGS:     rd_d = {23'h000000, background_block_ratio_over, severe_second_ratio_over, esr_over, lvl[5:0]};
			`ADDR_LEVEL:     rd_d = {24'h000000, level_q};
			default:         rd_d = 32'h00000000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rd_q <= 32'h00000000;
		else
			rd_q <= rd_en_i ? rd_d : 32'h00000000;
	end

	assign rd_data_o                     = rd_q;
	assign irq_o                         = |(stat_q & mask_q);
	assign tx_lock_status_o              = frame_lock_i;
	assign local_frame_loss_o            = !frame_lock_i;
	assign far_end_frame_loss_o          = !far_end_lock_i;
	assign link_outage_flag_o            = state_q == ST_OUTAGE;
	assign minor_rate_over_o             = minor_over;
	assign major_rate_over_o             = major_over;
	assign critical_rate_over_o          = crit_over;
	assign errored_second_ratio_over_o   = esr_over;
	assign severe_second_ratio_over_o    = severe_second_ratio_over;
	assign background_block_ratio_over_o = background_block_ratio_over;
	assign settings_rolled_back_o        = stat_q[`IRQ_ROLLBACK];
	assign received_level_gauge_o        = level_q;
	assign current_error_rate_o          = cur_rate_q;
	assign peak_error_rate_o             = peak_q;
endmodule // radio_link_performance_monitor

// >>> sim/link_partner_model.sv
// Far side model: decoder packet stream with a settable error mix
module link_partner_model
(
	input  wire       clk_i,
	input  wire       resetn_i,
	input  wire [1:0] err_mode_i,
	output logic      pkt_valid_o,
	output logic      pkt_uncorr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ph_q;
	// Packet every second cycle; idle error line toggles so it never looks settled
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ph_q <= 3'h0;
			pkt_valid_o <= 1'b0;
			pkt_uncorr_o <= 1'b0;
		end
		else
		begin
			ph_q <= ph_q + 3'h1;
			pkt_valid_o <= !ph_q[0];
			// Mode 1 all bad, mode 2 one in four bad
			pkt_uncorr_o <= ph_q[0] ? !pkt_uncorr_o :
				(err_mode_i == 2'h1) || (err_mode_i == 2'h2 && ph_q == 3'h0);
		end
	end
endmodule // link_partner_model

// >>> sim/radio_link_performance_monitor_sva.sv
// Port checker for the radio link performance monitor
`include "radio_link_map.vh"
module link_monitor_checker
#(
	parameter RATE_W = 16
)
(
	input wire              core_clk_i,
	input wire              resetn_i,
	input wire              frame_lock_i,
	input wire              far_end_lock_i,
	input wire [7:0]        rssi_dbm_i,
	input wire              rollback_evt_i,
	input wire [7:0]        addr_i,
	input wire [31:0]       wr_data_i,
	input wire              wr_en_i,
	input wire              tx_lock_status_o,
	input wire              local_frame_loss_o,
	input wire              far_end_frame_loss_o,
	input wire              link_outage_flag_o,
	input wire              minor_rate_over_o,
	input wire              settings_rolled_back_o,
	input wire [7:0]        received_level_gauge_o,
	input wire [RATE_W-1:0] current_error_rate_o,
	input wire [RATE_W-1:0] peak_error_rate_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Single domain; reset stops every check
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	property p_loc; local_frame_loss_o == !frame_lock_i; endproperty
	a_loc: assert property (p_loc) else $error("local loss wrong");
	property p_far; far_end_frame_loss_o == !far_end_lock_i && tx_lock_status_o == frame_lock_i;
	endproperty
	a_far: assert property (p_far) else $error("lock exchange wrong");
	property p_lvl; $past(resetn_i) |-> received_level_gauge_o == $past(rssi_dbm_i); endproperty
	a_lvl: assert property (p_lvl) else $error("level not raw");
	property p_rb_set; rollback_evt_i |-> ##[1:2] settings_rolled_back_o; endproperty
	a_rb_set: assert property (p_rb_set) else $error("rollback not flagged");
	property p_rb_clr; $fell(settings_rolled_back_o)
		|-> $past(wr_en_i && addr_i == `ADDR_IRQ_STAT && wr_data_i[`IRQ_ROLLBACK]); endproperty
	a_rb_clr: assert property (p_rb_clr) else $error("rollback dropped");
	// Results move only on period or second ticks, never twice in a row
	property p_out; $changed(link_outage_flag_o) |=> $stable(link_outage_flag_o)[*8]; endproperty
	a_out: assert property (p_out) else $error("outage toggles");
	property p_cur; $changed(current_error_rate_o) |=> $stable(current_error_rate_o)[*8];
	endproperty
	a_cur: assert property (p_cur) else $error("rate unsettled");
	property p_peak; $changed(peak_error_rate_o) |=> $stable(peak_error_rate_o)[*8]; endproperty
	a_peak: assert property (p_peak) else $error("peak unsettled");
	property p_minor; $changed(minor_rate_over_o) |=> $stable(minor_rate_over_o)[*8]; endproperty
	a_minor: assert property (p_minor) else $error("minor flag unsettled");
endmodule // link_monitor_checker

bind radio_link_performance_monitor link_monitor_checker #(.RATE_W(RATE_W)) u_chk
(
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .frame_lock_i(frame_lock_i),
	.far_end_lock_i(far_end_lock_i), .rssi_dbm_i(rssi_dbm_i), .rollback_evt_i(rollback_evt_i),
	.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
	.tx_lock_status_o(tx_lock_status_o), .local_frame_loss_o(local_frame_loss_o),
	.far_end_frame_loss_o(far_end_frame_loss_o), .link_outage_flag_o(link_outage_flag_o),
	.minor_rate_over_o(minor_rate_over_o), .settings_rolled_back_o(settings_rolled_back_o),
	.received_level_gauge_o(received_level_gauge_o),
	.current_error_rate_o(current_error_rate_o), .peak_error_rate_o(peak_error_rate_o)
);

// >>> sim/radio_link_performance_monitor_tb_top.sv
// Self-checking bench for the radio link performance monitor
`include "radio_link_map.vh"
module radio_link_performance_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam PER = 40;
	logic        core_clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [1:0]  err_mode = 2'h0;
	logic        frame_lock_i = 1'b1;
	logic        far_end_lock_i = 1'b1;
	logic [7:0]  rssi_dbm_i = 8'hB5;
	logic        rollback_evt_i = 1'b0;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wr_data_i = 32'h0;
	logic        wr_en_i = 1'b0;
	logic        rd_en_i = 1'b0;
	wire         pkt_valid_i, pkt_uncorr_i, irq_o, tx_lock_status_o, local_frame_loss_o;
	wire         far_end_frame_loss_o, link_outage_flag_o, minor_rate_over_o, major_rate_over_o;
	wire         critical_rate_over_o, errored_second_ratio_over_o, severe_second_ratio_over_o;
	wire         background_block_ratio_over_o, settings_rolled_back_o;
	wire [31:0]  rd_data_o;
	wire [7:0]   received_level_gauge_o;
	wire [15:0]  current_error_rate_o, peak_error_rate_o;
	int          error_cnt = 0;
	int          samples_checked = 0;
	// Short period keeps a simulated second at 160 cycles
	radio_link_performance_monitor #(.PERIOD_CYCLES(PER)) DUT
	(
		.core_clk_i, .resetn_i, .pkt_valid_i, .pkt_uncorr_i, .frame_lock_i, .far_end_lock_i,
		.rssi_dbm_i, .rollback_evt_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
		.irq_o, .tx_lock_status_o, .local_frame_loss_o, .far_end_frame_loss_o,
		.link_outage_flag_o, .minor_rate_over_o, .major_rate_over_o, .critical_rate_over_o,
		.errored_second_ratio_over_o, .severe_second_ratio_over_o,
		.background_block_ratio_over_o, .settings_rolled_back_o, .received_level_gauge_o,
		.current_error_rate_o, .peak_error_rate_o
	);
	link_partner_model partner
	(
		.clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.err_mode_i(err_mode),
		.pkt_valid_o(pkt_valid_i),
		.pkt_uncorr_o(pkt_uncorr_i)
	);
	always #25 core_clk_i = ~core_clk_i;
	task automatic chk_pin(input string nm, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %b seen %b", nm, exp, got);
		end
	endtask
	// One-cycle write; returns just after the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_en_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
		#1;
	endtask
	// Read data stands only in the cycle after the read edge
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		rd_en_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1;
		samples_checked++;
		if (rd_data_o !== exp)
		begin
			error_cnt++;
			$display("Error reg %h expected %h seen %h", a, exp, rd_data_o);
		end
	endtask
	task automatic finish_test;
		$display("Checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		wr(`ADDR_THR_MINOR, 32'h1000);
		wr(`ADDR_THR_MAJOR, 32'h8000);
		wr(`ADDR_THR_ESR, 32'h8000);
		wr(`ADDR_THR_BACKGROUND_BLOCK_RATIO, 32'hC000);
		err_mode <= 2'h1;
		wr(`ADDR_CTRL, 32'h1);
		// Twelve fully errored seconds
		repeat (12 * 4 * PER + 100) @(posedge core_clk_i);
		rchk(`ADDR_RATE, 32'hFFFFFFFF);
		rchk(`ADDR_ESR, 32'h0000FFFF);
		rchk(`ADDR_SEVERE_SECOND_RATIO, 32'h0000FFFF);
		rchk(`ADDR_BACKGROUND_BLOCK_RATIO, 32'h0000FFFF);
		rchk(`ADDR_UNAV_SECS, 32'h0000000C);
		chk_pin("major", 1'b1, major_rate_over_o);
		chk_pin("critical", 1'b0, critical_rate_over_o);
		chk_pin("outage", 1'b1, link_outage_flag_o);
		chk_pin("esr over", 1'b1, errored_second_ratio_over_o);
		chk_pin("severe_second_ratio over", 1'b0, severe_second_ratio_over_o);
		chk_pin("background_block_ratio over", 1'b1, background_block_ratio_over_o);
		chk_pin("level", 1'b1, (received_level_gauge_o + 8'h14) === 8'hC9);
		// Quarter bad stays below the severe share
		err_mode <= 2'h2;
		repeat (13 * 4 * PER) @(posedge core_clk_i);
		rchk(`ADDR_RATE, 32'h40004000);
		chk_pin("current pin", 1'b1, current_error_rate_o === 16'h4000);
		chk_pin("peak pin", 1'b1, peak_error_rate_o === 16'h4000);
		rchk(`ADDR_ESR, 32'h0000FFFF);
		// Severe changeover second stays booked, nine clean seconds handed back
		rchk(`ADDR_UNAV_SECS, 32'h0000000D);
		chk_pin("outage", 1'b0, link_outage_flag_o);
		chk_pin("major", 1'b0, major_rate_over_o);
		chk_pin("minor", 1'b1, minor_rate_over_o);
		chk_pin("background_block_ratio over", 1'b0, background_block_ratio_over_o);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk_i);
			frame_lock_i <= i[0];
			far_end_lock_i <= i[1];
			#1;
			chk_pin("local loss", !i[0], local_frame_loss_o);
			chk_pin("far loss", !i[1], far_end_frame_loss_o);
			chk_pin("tx lock", i[0], tx_lock_status_o);
		end
		// Masked, then unmasked, then cleared rollback event
		wr(`ADDR_IRQ_MASK, 32'h0);
		wr(`ADDR_IRQ_STAT, 32'hFF);
		@(posedge core_clk_i);
		rollback_evt_i <= 1'b1;
		@(posedge core_clk_i);
		rollback_evt_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
		chk_pin("rolled back", 1'b1, settings_rolled_back_o);
		chk_pin("irq masked", 1'b0, irq_o);
		wr(`ADDR_IRQ_MASK, 32'h40);
		chk_pin("irq", 1'b1, irq_o);
		wr(`ADDR_IRQ_STAT, 32'h40);
		chk_pin("irq cleared", 1'b0, irq_o);
		chk_pin("rolled back", 1'b0, settings_rolled_back_o);
		rchk(8'hFC, 32'h0);
		// Stop first so no division lands across the counter clear
		wr(`ADDR_CTRL, 32'h0);
		repeat (20) @(posedge core_clk_i);
		wr(`ADDR_CTRL, 32'h2);
		rchk(`ADDR_TOT_SECS, 32'h0);
		rchk(`ADDR_RATE, 32'h0);
		finish_test;
	end
	// Watchdog well beyond the expected run
	initial
	begin
		repeat (9000) @(posedge core_clk_i);
		error_cnt++;
		finish_test;
	end
endmodule // radio_link_performance_monitor_tb_top
